/* include/ppg_consts.vh */
`ifndef PPG_CONSTS_VH
`define PPG_CONSTS_VH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PPG_OFS_TBCTL   12'h000
`define PPG_OFS_PERIOD  12'h004
`define PPG_OFS_DUTY    12'h008
`define PPG_OFS_PHASE   12'h00c
`define PPG_OFS_OUTCTL  12'h010
`define PPG_OFS_DTIME   12'h014
`define PPG_OFS_TRGCTL  12'h018
`define PPG_OFS_TRGCMP  12'h01c
`define PPG_OFS_SEVCMP  12'h020
`define PPG_OFS_ISTAT   12'h024
`define PPG_OFS_ICLR    12'h028
`define PPG_OFS_IEN     12'h02c
`define PPG_OFS_COUNT   12'h030
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PPG_TB_EN_BIT    15
`define PPG_TB_IMMEDIATE_PERIOD_UPDATE_BIT  10
`define PPG_OC_MODE_HI   11
`define PPG_OC_MODE_LO   10
`define PPG_OC_CENTER    1
`define PPG_OC_SWAP      0
`define PPG_TC_DIV_HI    15
`define PPG_TC_DIV_LO    12
`define PPG_TC_STRT_HI   5
`define PPG_TC_STRT_LO   0
`define PPG_IRQ_SEV      0
`define PPG_IRQ_TRG      1
`define PPG_IRQ_PER      2
// ----------------------------------------------------------------
// Mode codes and reset values
// ----------------------------------------------------------------
`define PPG_MODE_COMPL   2'b00
`define PPG_MODE_REDUND  2'b01
`define PPG_MODE_PUSHPL  2'b10
`define PPG_RST_PERIOD   16'hffff
`define PPG_RST_ZERO16   16'h0000
`endif

/* hdl/ppg_top.v */
`timescale 1ns/1ps
`include "ppg_consts.vh"
module ppg_top
(
   input  wire        mclk_i,
   input  wire        rst_i,
   input  wire        psel_i,
   input  wire        penable_i,
   input  wire        pwrite_i,
   input  wire [11:0] paddr_i,
   input  wire [31:0] pwdata_i,
   output reg  [31:0] prdata_o,
   output reg         pready_o,
   output reg         pslverr_o,
   output reg         high_side_output_o,
   output reg         low_side_output_o,
   output reg         trigger_o,
   output reg         irq_o
);
   // ----------------------------------------------------------------
   // Registers and state
   // ----------------------------------------------------------------
   reg [15:0] tbctl_r;
   reg [15:0] per_pend_r;
   reg [15:0] per_act_r;
   reg [15:0] duty_r;
   reg [15:0] phase_shift_value_r;
   reg [15:0] outctl_r;
   reg [15:0] dtime_r;
   reg [15:0] trgctl_r;
   reg [15:0] primary_trigger_compare_r;
   reg [15:0] special_event_compare_r;
   reg [2:0]  istat_r;
   reg [2:0]  ien_r;
   reg [15:0] cnt_r;
   reg        down_r;
   reg [5:0]  cyc_r;
   reg [3:0]  div_r;
   reg        last_pin_r;
   reg        pp_act_r;
   reg        tgt_h_r;
   reg        tgt_l_r;
   reg [15:0] dt_cnt_r;
   // Combinational helpers
   reg [15:0] cnt_nxt;
   reg        down_nxt;
   reg        bound;
   reg        tgt_h;
   reg        tgt_l;
   reg        dt_busy;
   reg [31:0] rdata;
   reg        rerr;
   wire        wr_en;
   wire        setup;
   wire        pwm_module_enable;
   wire        immediate_period_update;
   wire [1:0]  out_mode;
   wire        center;
   wire        swap;
   wire [3:0]  trigger_output_divider;
   wire [5:0]  trigger_postscaler_start;
   wire        raw;
   wire        trg_match;
   wire        sev_match;
   wire        trg_issue;
   wire        tgt_chg;
   wire [2:0]  ev;

   assign setup = psel_i & ~penable_i;
   assign wr_en = psel_i & penable_i & pready_o & pwrite_i & ~pslverr_o;
   assign pwm_module_enable       = tbctl_r[`PPG_TB_EN_BIT];
   assign immediate_period_update = tbctl_r[`PPG_TB_IMMEDIATE_PERIOD_UPDATE_BIT];
   assign out_mode = outctl_r[`PPG_OC_MODE_HI:`PPG_OC_MODE_LO];
   assign center   = outctl_r[`PPG_OC_CENTER];
   assign swap     = outctl_r[`PPG_OC_SWAP];
   assign trigger_output_divider =
      trgctl_r[`PPG_TC_DIV_HI:`PPG_TC_DIV_LO];
   assign trigger_postscaler_start =
      trgctl_r[`PPG_TC_STRT_HI:`PPG_TC_STRT_LO];

   // ----------------------------------------------------------------
   // APB read decode
   // ----------------------------------------------------------------
   always @*
   begin
      rdata = 32'h00000000;
      rerr  = 1'b0;
      if (paddr_i == `PPG_OFS_TBCTL)
         rdata[15:0] = tbctl_r;
      else if (paddr_i == `PPG_OFS_PERIOD)
         rdata[15:0] = per_pend_r;
      else if (paddr_i == `PPG_OFS_DUTY)
         rdata[15:0] = duty_r;
      else if (paddr_i == `PPG_OFS_PHASE)
         rdata[15:0] = phase_shift_value_r;
      else if (paddr_i == `PPG_OFS_OUTCTL)
         rdata[15:0] = outctl_r;
      else if (paddr_i == `PPG_OFS_DTIME)
         rdata[15:0] = dtime_r;
      else if (paddr_i == `PPG_OFS_TRGCTL)
         rdata[15:0] = trgctl_r;
      else if (paddr_i == `PPG_OFS_TRGCMP)
         rdata[15:0] = primary_trigger_compare_r;
      else if (paddr_i == `PPG_OFS_SEVCMP)
         rdata[15:0] = special_event_compare_r;
      else if (paddr_i == `PPG_OFS_ISTAT)
         rdata[2:0] = istat_r;
      else if (paddr_i == `PPG_OFS_ICLR)
         rdata = 32'h00000000;      // Write-only, reads zero
      else if (paddr_i == `PPG_OFS_IEN)
         rdata[2:0] = ien_r;
      else if (paddr_i == `PPG_OFS_COUNT)
         rdata[15:0] = cnt_r;
      else
         rerr = 1'b1;
   end

   // One wait-free answer: ready raised in setup, seen in access
   always @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         prdata_o  <= 32'h00000000;
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
      end
      else
      begin
         pready_o  <= setup;
         pslverr_o <= setup & rerr;
         if (setup)
            prdata_o <= pwrite_i ? 32'h00000000 : rdata;
      end
   end

   // ----------------------------------------------------------------
   // Time base: edge or center aligned, phase loaded at start
   // ----------------------------------------------------------------
   always @*
   begin
      cnt_nxt  = cnt_r + 16'h0001;
      down_nxt = down_r;
      bound    = 1'b0;
      if (!pwm_module_enable)
      begin
         cnt_nxt  = phase_shift_value_r;
         down_nxt = 1'b0;
      end
      else if (!center)
      begin
         if (cnt_r >= per_act_r)
         begin
            cnt_nxt = 16'h0000;
            bound   = 1'b1;
         end
      end
      else if (!down_r)
      begin
         if (cnt_r >= per_act_r)
         begin
            cnt_nxt  = cnt_r - 16'h0001;
            down_nxt = 1'b1;
         end
      end
      else if (cnt_r == 16'h0000)
      begin
         cnt_nxt  = 16'h0001;
         down_nxt = 1'b0;
         bound    = 1'b1;
      end
      else
         cnt_nxt = cnt_r - 16'h0001;
   end

   assign raw       = pwm_module_enable & (cnt_r < duty_r);
   assign trg_match = pwm_module_enable &
                      (cnt_r == primary_trigger_compare_r);
   assign sev_match = pwm_module_enable &
                      (cnt_r == special_event_compare_r);
   // Issue on divider count zero: first eligible match always fires
   assign trg_issue = trg_match &
                      (cyc_r >= trigger_postscaler_start) &
                      (div_r == 4'h0);
   assign ev = {bound, trg_issue, sev_match};

   // ----------------------------------------------------------------
   // Control registers, time base and trigger state
   // ----------------------------------------------------------------
   always @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         tbctl_r    <= `PPG_RST_ZERO16;
         per_pend_r <= `PPG_RST_PERIOD;
         per_act_r  <= `PPG_RST_PERIOD;
         duty_r     <= `PPG_RST_ZERO16;
         phase_shift_value_r       <= `PPG_RST_ZERO16;
         outctl_r   <= `PPG_RST_ZERO16;
         dtime_r    <= `PPG_RST_ZERO16;
         trgctl_r   <= `PPG_RST_ZERO16;
         primary_trigger_compare_r <= `PPG_RST_ZERO16;
         special_event_compare_r   <= `PPG_RST_ZERO16;
         ien_r      <= 3'h0;
         istat_r    <= 3'h0;
         cnt_r      <= `PPG_RST_ZERO16;
         down_r     <= 1'b0;
         cyc_r      <= 6'h00;
         div_r      <= 4'h0;
         trigger_o  <= 1'b0;
         irq_o      <= 1'b0;
      end
      else
      begin
         cnt_r  <= cnt_nxt;
         down_r <= down_nxt;
         // Register writes
         if (wr_en && paddr_i == `PPG_OFS_TBCTL)
            tbctl_r <= pwdata_i[15:0];
         if (wr_en && paddr_i == `PPG_OFS_DUTY)
            duty_r <= pwdata_i[15:0];
         if (wr_en && paddr_i == `PPG_OFS_PHASE)
            phase_shift_value_r <= pwdata_i[15:0];
         if (wr_en && paddr_i == `PPG_OFS_OUTCTL)
            outctl_r <= pwdata_i[15:0];
         if (wr_en && paddr_i == `PPG_OFS_DTIME)
            dtime_r <= pwdata_i[15:0];
         if (wr_en && paddr_i == `PPG_OFS_TRGCTL)
            trgctl_r <= pwdata_i[15:0];
         if (wr_en && paddr_i == `PPG_OFS_TRGCMP)
            primary_trigger_compare_r <= pwdata_i[15:0];
         if (wr_en && paddr_i == `PPG_OFS_SEVCMP)
            special_event_compare_r <= pwdata_i[15:0];
         if (wr_en && paddr_i == `PPG_OFS_IEN)
            ien_r <= pwdata_i[2:0];
         // Period: pending copy, applied now or at boundary
         if (wr_en && paddr_i == `PPG_OFS_PERIOD)
         begin
            per_pend_r <= pwdata_i[15:0];
            if (immediate_period_update)
               per_act_r <= pwdata_i[15:0];
         end
         else if (bound || !pwm_module_enable)
            per_act_r <= per_pend_r;
         // Postscaler start: count cycles since enable
         if (!pwm_module_enable)
            cyc_r <= 6'h00;
         else if (bound && cyc_r != 6'h3f)
            cyc_r <= cyc_r + 6'h01;
         // Divider counts eligible matches, first one included
         if (!pwm_module_enable)
            div_r <= 4'h0;
         else if (trg_match && cyc_r >= trigger_postscaler_start)
         begin
            if (div_r == trigger_output_divider)
               div_r <= 4'h0;
            else
               div_r <= div_r + 4'h1;
         end
         trigger_o <= trg_issue;
         // Sticky status: set wins over clear
         if (wr_en && paddr_i == `PPG_OFS_ICLR)
            istat_r <= (istat_r & ~pwdata_i[2:0]) | ev;
         else
            istat_r <= istat_r | ev;
         irq_o <= |(istat_r & ien_r);
      end
   end

   // ----------------------------------------------------------------
   // Output steering: mode, push-pull alternation, swap
   // ----------------------------------------------------------------
   always @*
   begin
      tgt_h = 1'b0;
      tgt_l = 1'b0;
      case (out_mode)
         `PPG_MODE_COMPL:
         begin
            tgt_h = raw;
            tgt_l = pwm_module_enable & ~raw;
         end
         `PPG_MODE_REDUND:
         begin
            tgt_h = raw;
            tgt_l = raw;
         end
         `PPG_MODE_PUSHPL:
         begin
            tgt_h = raw & ~last_pin_r;
            tgt_l = raw & last_pin_r;
         end
         default:
         begin
            tgt_h = 1'b0;
            tgt_l = 1'b0;
         end
      endcase
      if (swap)
      begin
         tgt_h = (out_mode == `PPG_MODE_PUSHPL) ?
                 (raw & last_pin_r) :
                 ((out_mode == `PPG_MODE_COMPL) ?
                  (pwm_module_enable & ~raw) : tgt_h);
         tgt_l = (out_mode == `PPG_MODE_PUSHPL) ?
                 (raw & ~last_pin_r) :
                 ((out_mode == `PPG_MODE_COMPL) ? raw : tgt_l);
      end
   end

   // Any change of target, swap toggles included, restarts dead time
   assign tgt_chg = (tgt_h != tgt_h_r) | (tgt_l != tgt_l_r);

   always @*
   begin
      if (tgt_chg)
         dt_busy = (dtime_r != 16'h0000);
      else
         dt_busy = (dt_cnt_r != 16'h0000);
   end

   // ----------------------------------------------------------------
   // Dead time and pin flip-flops
   // ----------------------------------------------------------------
   always @(posedge mclk_i)
   begin
      if (rst_i)
      begin
         tgt_h_r    <= 1'b0;
         tgt_l_r    <= 1'b0;
         dt_cnt_r   <= `PPG_RST_ZERO16;
         last_pin_r <= 1'b0;
         pp_act_r   <= 1'b0;
         high_side_output_o <= 1'b0;
         low_side_output_o  <= 1'b0;
      end
      else
      begin
         tgt_h_r <= tgt_h;
         tgt_l_r <= tgt_l;
         if (tgt_chg)
            dt_cnt_r <= dtime_r;
         else if (dt_cnt_r != 16'h0000)
            dt_cnt_r <= dt_cnt_r - 16'h0001;
         // Pin flips only after its pulse ends: no two in a row
         pp_act_r <= raw;
         if (out_mode != `PPG_MODE_PUSHPL || !pwm_module_enable)
            last_pin_r <= 1'b0;
         else if (pp_act_r && !raw)
            last_pin_r <= ~last_pin_r;
         // Complementary mode only: turn-off at once, turn-on only after dead time
         if (out_mode == `PPG_MODE_COMPL)
         begin
            high_side_output_o <= tgt_h &
                                  (~dt_busy | high_side_output_o);
            low_side_output_o  <= tgt_l &
                                  (~dt_busy | low_side_output_o);
         end
         else
         begin
            high_side_output_o <= tgt_h;
            low_side_output_o  <= tgt_l;
         end
      end
   end
endmodule

/* verif/ppg_chk.sv */
`timescale 1ns/1ps
`include "ppg_consts.vh"
module ppg_chk
(
   input wire        mclk_i,
   input wire        rst_i,
   input wire        psel_i,
   input wire        penable_i,
   input wire        pwrite_i,
   input wire [11:0] paddr_i,
   input wire [31:0] pwdata_i,
   input wire [31:0] prdata_o,
   input wire        pready_o,
   input wire        pslverr_o,
   input wire        high_side_output_o,
   input wire        low_side_output_o,
   input wire        trigger_o,
   input wire        irq_o
);
   reg  [1:0]  mode_r;
   reg  [15:0] dt_r;
   reg  [1:0]  last_r;
   reg  [15:0] gap_r;
   reg         hi_q;
   reg         lo_q;
   wire        wr_w = psel_i & penable_i & pready_o & pwrite_i;
   wire        setup_w = psel_i & ~penable_i;
   wire        bad_w = (paddr_i > `PPG_OFS_COUNT) | (paddr_i[1:0] != 2'b00);
   wire        hi_w = high_side_output_o;
   wire        lo_w = low_side_output_o;
   // Shadow of mode, dead time, last pulse pin and idle gap
   always @(posedge mclk_i)
   begin
      hi_q <= hi_w;
      lo_q <= lo_w;
      if (rst_i | (wr_w & (paddr_i == `PPG_OFS_OUTCTL)))
         last_r <= 2'b00;
      else if (hi_w & ~hi_q)
         last_r <= 2'b01;
      else if (lo_w & ~lo_q)
         last_r <= 2'b10;
      if (rst_i)
         mode_r <= 2'b00;
      else if (wr_w & (paddr_i == `PPG_OFS_OUTCTL))
         mode_r <= pwdata_i[11:10];
      if (rst_i)
         dt_r <= 16'h0000;
      else if (wr_w & (paddr_i == `PPG_OFS_DTIME))
         dt_r <= pwdata_i[15:0];
      if (rst_i | hi_w | lo_w)
         gap_r <= rst_i ? 16'hffff : 16'h0000;
      else if (gap_r != 16'hffff)
         gap_r <= gap_r + 16'h0001;
   end
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   property p_rdy; setup_w |=> pready_o; endproperty
   a_rdy: assert property (p_rdy) else $error("pready missing");
   property p_rdy_src; pready_o |-> $past(setup_w); endproperty
   a_rdy_src: assert property (p_rdy_src) else $error("stray pready");
   property p_err; setup_w |=> (pslverr_o == bad_w); endproperty
   a_err: assert property (p_err) else $error("pslverr wrong");
   property p_err_rd; pslverr_o & ~pwrite_i |-> prdata_o == 32'h0; endproperty
   a_err_rd: assert property (p_err_rd) else $error("refused read data");
   property p_rst;
      disable iff (1'b0) rst_i |=> !(irq_o | trigger_o | hi_w | lo_w);
   endproperty
   a_rst: assert property (p_rst) else $error("outputs not cleared");
   property p_pp_excl; mode_r == 2'b10 |-> !(hi_w & lo_w); endproperty
   a_pp_excl: assert property (p_pp_excl) else $error("both pins on");
   property p_alt_h; mode_r == 2'b10 && $rose(hi_w) |-> last_r != 2'b01;
   endproperty
   a_alt_h: assert property (p_alt_h) else $error("high pulse repeat");
   property p_alt_l; mode_r == 2'b10 && $rose(lo_w) |-> last_r != 2'b10;
   endproperty
   a_alt_l: assert property (p_alt_l) else $error("low pulse repeat");
   property p_dead;
      mode_r == 2'b00 && ($rose(hi_w) || $rose(lo_w)) |-> gap_r >= dt_r;
   endproperty
   a_dead: assert property (p_dead) else $error("dead time short");
   property p_trg; trigger_o |=> !trigger_o; endproperty
   a_trg: assert property (p_trg) else $error("trigger too long");
   property p_mask;
      wr_w && paddr_i == `PPG_OFS_IEN && pwdata_i[2:0] == 3'b000 |-> ##2 !irq_o;
   endproperty
   a_mask: assert property (p_mask) else $error("masked irq high");
   c_trg: cover property (trigger_o);
   c_err: cover property (pslverr_o);
   c_pp: cover property (mode_r == 2'b10 && $rose(lo_w));
endmodule
bind ppg_top ppg_chk u_chk (.mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
   .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
   .pslverr_o(pslverr_o), .high_side_output_o(high_side_output_o),
   .low_side_output_o(low_side_output_o), .trigger_o(trigger_o),
   .irq_o(irq_o));

/* verif/test_ppg_top.sv */
`timescale 1ns/1ps
`include "ppg_consts.vh"
module test_ppg_top;
   reg         mclk_i = 1'b0;
   reg         rst_i = 1'b1;
   reg         psel_i = 1'b0;
   reg         penable_i = 1'b0;
   reg         pwrite_i = 1'b0;
   reg  [11:0] paddr_i = 12'h000;
   reg  [31:0] pwdata_i = 32'h0;
   wire [31:0] prdata_o;
   wire        pready_o;
   wire        pslverr_o;
   wire        hi;
   wire        lo;
   wire        trig;
   wire        irq;
   integer     n_errors = 0;
   integer     checks = 0;
   integer     cyc = 0;
   integer     n_trg = 0;
   integer     n_hi = 0;
   integer     n_lo = 0;
   reg         hi_q = 1'b0;
   reg         lo_q = 1'b0;
   reg  [31:0] q;
   reg         e;
   reg  [11:0] a;
   integer     bh;
   integer     bl;
   always #10 mclk_i = ~mclk_i;
   ppg_top u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
      .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
      .pslverr_o(pslverr_o), .high_side_output_o(hi),
      .low_side_output_o(lo), .trigger_o(trig), .irq_o(irq));
   // ------------------------------------------------------------
   // Tallies, timeout and helper tasks
   // ------------------------------------------------------------
   always @(posedge mclk_i)
   begin
      cyc <= cyc + 1;
      hi_q <= hi;
      lo_q <= lo;
      if (trig === 1'b1) n_trg <= n_trg + 1;
      if (hi === 1'b1 && hi_q === 1'b0) n_hi <= n_hi + 1;
      if (lo === 1'b1 && lo_q === 1'b0) n_lo <= n_lo + 1;
      if (cyc == 5000)
      begin
         n_errors = n_errors + 1;
         print_verdict;
      end
   end
   task print_verdict;
   begin
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   end
   endtask
   task chk(input [31:0] s, input [31:0] x);
   begin
      checks = checks + 1;
      if (s !== x)
      begin
         n_errors = n_errors + 1;
         $display("mismatch at %0t: got %h want %h", $time, s, x);
      end
   end
   endtask
   task apb(input w, input [11:0] ad, input [31:0] d);
      integer k;
   begin
      @(posedge mclk_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= w;
      paddr_i <= ad;
      pwdata_i <= d;
      @(posedge mclk_i);
      penable_i <= 1'b1;
      k = 0;
      do begin @(posedge mclk_i); k = k + 1; end
      while (pready_o !== 1'b1 && k < 16);
      if (pready_o !== 1'b1)
      begin
         n_errors = n_errors + 1;
         $display("mismatch at %0t: no pready", $time);
      end
      q = prdata_o;
      e = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   end
   endtask
   task wr(input [11:0] ad, input [31:0] d); apb(1'b1, ad, d); endtask
   task rd(input [11:0] ad); apb(1'b0, ad, 32'h0); endtask
   task do_reset;
   begin
      @(posedge mclk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      rst_i <= 1'b0;
   end
   endtask
   task run_trig(input [3:0] dv, input [5:0] st);
      integer m;
      integer x;
      integer b;
   begin
      do_reset;
      wr(`PPG_OFS_PERIOD, 32'd19);
      wr(`PPG_OFS_TRGCMP, 32'd3);
      wr(`PPG_OFS_TRGCTL, {16'h0, dv, 6'h0, st});
      wr(`PPG_OFS_SEVCMP, 32'd5);
      wr(`PPG_OFS_IEN, 32'd7);
      x = 0;
      for (m = 0; m < 5; m = m + 1)
         if (m >= st && (m - st) % (dv + 1) == 0) x = x + 1;
      wr(`PPG_OFS_TBCTL, 32'h8000);
      b = n_trg;
      repeat (90) @(posedge mclk_i);
      wr(`PPG_OFS_TBCTL, 32'h0);
      chk(n_trg - b, x);
   end
   endtask
   // Main sequence
   initial
   begin
      repeat (12) @(posedge mclk_i);
      rst_i <= 1'b0;
      for (a = 12'h000; a <= `PPG_OFS_COUNT; a = a + 12'h004)
      begin
         rd(a);
         chk(q, (a == `PPG_OFS_PERIOD) ? 32'hffff : 32'h0);
      end
      wr(12'h040, 32'h5a5a);
      chk({31'b0, e}, 1);
      rd(12'h040);
      chk(q, 0);
      wr(`PPG_OFS_PHASE, 32'h7);
      rd(`PPG_OFS_COUNT);
      chk(q, 7);
      run_trig(4'd0, 6'd0);
      rd(`PPG_OFS_ISTAT);
      chk(q & 32'h7, 7);
      chk({31'b0, irq}, 1);
      wr(`PPG_OFS_IEN, 32'h0);
      repeat (2) @(posedge mclk_i);
      chk({31'b0, irq}, 0);
      wr(`PPG_OFS_IEN, 32'h7);
      wr(`PPG_OFS_ICLR, 32'h7);
      repeat (2) @(posedge mclk_i);
      chk({31'b0, irq}, 0);
      rd(`PPG_OFS_ISTAT);
      chk(q, 0);
      run_trig(4'd2, 6'd0);
      run_trig(4'd0, 6'd2);
      // Push-pull alternation and period update timing
      do_reset;
      wr(`PPG_OFS_OUTCTL, 32'h800);
      wr(`PPG_OFS_PHASE, 32'd10);
      wr(`PPG_OFS_PERIOD, 32'd19);
      wr(`PPG_OFS_DUTY, 32'd5);
      wr(`PPG_OFS_TBCTL, 32'h8000);
      bh = n_hi;
      bl = n_lo;
      repeat (80) @(posedge mclk_i);
      wr(`PPG_OFS_TBCTL, 32'h0);
      chk(n_hi - bh, 2);
      chk(n_lo - bl, 2);
      wr(`PPG_OFS_PERIOD, 32'd99);
      wr(`PPG_OFS_TBCTL, 32'h8000);
      repeat (40) @(posedge mclk_i);
      wr(`PPG_OFS_PERIOD, 32'd9);
      rd(`PPG_OFS_COUNT);
      chk({31'b0, q > 9}, 1);
      rd(`PPG_OFS_PERIOD);
      chk(q, 9);
      repeat (60) @(posedge mclk_i);
      rd(`PPG_OFS_COUNT);
      chk({31'b0, q <= 9}, 1);
      wr(`PPG_OFS_TBCTL, 32'h8400);
      wr(`PPG_OFS_PERIOD, 32'd99);
      repeat (30) @(posedge mclk_i);
      rd(`PPG_OFS_COUNT);
      chk({31'b0, q > 9}, 1);
      wr(`PPG_OFS_PERIOD, 32'd5);
      repeat (2) @(posedge mclk_i);
      rd(`PPG_OFS_COUNT);
      chk({31'b0, q <= 5}, 1);
      // Center-aligned complementary with dead time and swap
      do_reset;
      wr(`PPG_OFS_OUTCTL, 32'h2);
      wr(`PPG_OFS_DTIME, 32'd4);
      wr(`PPG_OFS_TRGCMP, 32'd7);
      wr(`PPG_OFS_PERIOD, 32'd19);
      wr(`PPG_OFS_DUTY, 32'd20);
      wr(`PPG_OFS_TBCTL, 32'h8000);
      repeat (20) @(posedge mclk_i);
      chk({30'b0, hi, lo}, 2);
      wr(`PPG_OFS_OUTCTL, 32'h3);
      repeat (20) @(posedge mclk_i);
      chk({30'b0, hi, lo}, 1);
      wr(`PPG_OFS_OUTCTL, 32'h2);
      repeat (20) @(posedge mclk_i);
      chk({30'b0, hi, lo}, 2);
      wr(`PPG_OFS_DUTY, 32'd10);
      repeat (80) @(posedge mclk_i);
      print_verdict;
   end
endmodule
